// ### bench/fsc_cmd_sva.sv
// assertions for the serial command front end
// assumes it is bound to fsc_cmd_top and sees only its ports
`timescale 1ns/1ps
module fsc_cmd_sva (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // watched ports
    input wire select_n_i,
    input wire sdo_o,
    input wire sdo_oe_o,
    input wire coef_req_o,
    input wire wr_strobe_o,
    input wire temp_refresh_o,
    input wire boot_o,
    input wire conv_run_o,
    input wire [1:0] state_o
);
    // ==========================================================
    // link and state relations
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    AST_SDO_REST: assert property (!sdo_oe_o |-> sdo_o)
        else $error("sdo low outside a frame");
    AST_OE_OFF: assert property (select_n_i [*6] |-> !sdo_oe_o)
        else $error("sdo driven without select");
    AST_OE_ON: assert property (!select_n_i [*6] |-> sdo_oe_o)
        else $error("sdo not driven in frame");
    AST_CONV: assert property (conv_run_o == ($past(state_o) == 2'h1))
        else $error("conversion run does not follow state");
    AST_TEMP: assert property (temp_refresh_o |-> wr_strobe_o
        && state_o == 2'h1)
        else $error("temperature refresh outside active write");
    AST_BOOT_ONE: assert property (boot_o |=> !boot_o)
        else $error("boot pulse longer than one cycle");
    AST_WAKE: assert property ($past(state_o) == 2'h0
        && state_o != 2'h0 |-> boot_o || $past(boot_o))
        else $error("left shutdown without boot");
    AST_SHUT_QUIET: assert property (state_o == 2'h0
        |-> !coef_req_o && !wr_strobe_o)
        else $error("fetch or write acted on in shutdown");
endmodule // fsc_cmd_sva

bind fsc_cmd_top fsc_cmd_sva fsc_cmd_sva_i (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .select_n_i(select_n_i),
    .sdo_o(sdo_o),
    .sdo_oe_o(sdo_oe_o),
    .coef_req_o(coef_req_o),
    .wr_strobe_o(wr_strobe_o),
    .temp_refresh_o(temp_refresh_o),
    .boot_o(boot_o),
    .conv_run_o(conv_run_o),
    .state_o(state_o)
);

// ### bench/fsc_host_model.sv
// host controller driving the mode-3 serial link
// assumes the bench calls its tasks just after a falling clk edge
`timescale 1ns/1ps
module fsc_host_model (
    // serial link, host side
    output reg sclk_o,
    output reg select_n_o,
    output reg sdi_o,
    input wire sdo_i
);
    // ==========================================================
    // frame and bit tasks, 800 ns serial period
    localparam HALF = 400;

    initial begin
        sclk_o = 1'b1;
        select_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    task open_frame;
        begin
            #13;
            select_n_o = 1'b0;
            #HALF;
        end
    endtask

    task xfer(input [7:0] tx, output [7:0] rx);
        integer i;
        begin
            for (i = 7; i >= 0; i = i - 1) begin
                sclk_o = 1'b0;
                sdi_o = tx[i];
                #HALF;
                sclk_o = 1'b1;
                rx[i] = sdo_i;
                #HALF;
            end
        end
    endtask

    task close_frame;
        begin
            #100;
            select_n_o = 1'b1;
            // released line shows no stale level
            sdi_o = ~sdi_o;
            #1000;
        end
    endtask
endmodule // fsc_host_model

// ### bench/test_sensor_spi_command_state_machine.sv
// self-checking bench for the serial command front end
// assumes fsc_map.vh on the include path; host model drives the link
`timescale 1ns/1ps
`include "fsc_map.vh"
module test_sensor_spi_command_state_machine;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg [23:0] meas = 24'h0000_00;
    reg [23:0] temp = 24'h0000_00;
    reg [7:0] coef = 8'h00;
    reg coef_valid = 1'b0;
    wire sclk, select_n, sdi, sdo, coef_req, wr_strobe, temp_refresh, boot;
    wire [7:0] coef_addr, wr_addr, wr_data;
    wire [1:0] state;
    integer n_errors = 0, total_checks = 0, n_boot = 0, n_temp = 0;
    integer coef_cnt = -1, coef_wait = 0, i, k, b;
    reg [7:0] rx, a, d;
    reg [1:0] mst = `FSC_ST_SHUT;
    reg [23:0] got;

    always #50 clk_i = ~clk_i;

    fsc_cmd_top fsc_cmd_top_i (.clk_i(clk_i), .rst_i(rst_i),
        .sclk_i(sclk), .select_n_i(select_n), .sdi_i(sdi), .sdo_o(sdo),
        .sdo_oe_o(), .meas_data_i(meas), .temp_data_i(temp),
        .coef_data_i(coef), .coef_valid_i(coef_valid),
        .coef_req_o(coef_req), .coef_addr_o(coef_addr),
        .wr_strobe_o(wr_strobe), .wr_addr_o(wr_addr), .wr_data_o(wr_data),
        .temp_refresh_o(temp_refresh), .boot_o(boot), .conv_run_o(),
        .state_o(state));
    fsc_host_model fsc_host_model_i (.sclk_o(sclk), .select_n_o(select_n),
        .sdi_o(sdi), .sdo_i(sdo));

    // ==========================================================
    // coefficient memory stub and pulse counters
    always @(negedge clk_i) begin
        coef_valid <= 1'b0;
        if (coef_req) coef_cnt = 0;
        else if (coef_cnt >= 0) coef_cnt = coef_cnt + 1;
        if (coef_cnt == coef_wait) coef_valid <= 1'b1;
    end
    always @(negedge clk_i) begin
        if (boot) n_boot = n_boot + 1;
        if (temp_refresh) n_temp = n_temp + 1;
    end

    function [7:0] exp_ack(input [7:0] c, input [1:0] s);
        case (c)
            `FSC_CMD_RESET, `FSC_CMD_SHUTDOWN, `FSC_CMD_IDLE:
                exp_ack = `FSC_BYTE_ACK;
            `FSC_CMD_ACTIVE: exp_ack = (s == `FSC_ST_ACTIVE) ?
                `FSC_BYTE_NACK : `FSC_BYTE_ACK;
            `FSC_CMD_RESULT, `FSC_CMD_TEMP, `FSC_CMD_WRITE, `FSC_CMD_FETCH:
                exp_ack = (s == `FSC_ST_SHUT) ?
                `FSC_BYTE_NACK : `FSC_BYTE_ACK;
            default: exp_ack = `FSC_BYTE_NACK;
        endcase
    endfunction
    function [1:0] exp_state(input [7:0] c, input [1:0] s);
        case (c)
            `FSC_CMD_RESET, `FSC_CMD_SHUTDOWN: exp_state = `FSC_ST_SHUT;
            `FSC_CMD_ACTIVE: exp_state = `FSC_ST_ACTIVE;
            `FSC_CMD_IDLE: exp_state = `FSC_ST_IDLE;
            default: exp_state = s;
        endcase
    endfunction
    function [23:0] exp_boot(input [7:0] c, input [1:0] s);
        exp_boot = {23'h0, c == `FSC_CMD_RESET || (s == `FSC_ST_SHUT
            && (c == `FSC_CMD_ACTIVE || c == `FSC_CMD_IDLE))};
    endfunction

    task check(input string what, input logic [23:0] seen, exp);
        begin
            total_checks = total_checks + 1;
            if (seen !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch %s expected %h seen %h", what, exp, seen);
            end
        end
    endtask
    task wrap_up;
        begin
            $display("checks %0d mismatches %0d", total_checks, n_errors);
            if (n_errors == 0 && total_checks > 0)
                $display("Run complete: PASS");
            else
                $display("Run complete: FAIL");
            $finish;
        end
    endtask
    task cmd(input [7:0] c);
        begin
            @(negedge clk_i);
            fsc_host_model_i.open_frame;
            fsc_host_model_i.xfer(c, rx);
            check("command echo", rx, `FSC_BYTE_NACK);
            fsc_host_model_i.xfer(8'h00, rx);
            check("answer", rx, exp_ack(c, mst));
        end
    endtask
    task steps(input [63:0] list, input integer n);
        for (i = 0; i < n; i = i + 1) begin
            b = n_boot;
            cmd(list[63-8*i -: 8]);
            fsc_host_model_i.close_frame;
            check("boot", n_boot - b, exp_boot(list[63-8*i -: 8], mst));
            mst = exp_state(list[63-8*i -: 8], mst);
            check("state", state, mst);
        end
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        @(negedge clk_i);
        rst_i = 1'b0;
        k = $urandom(32'h14f5);
        repeat (4) @(negedge clk_i);
        check("reset state", state, `FSC_ST_SHUT);
        steps({`FSC_CMD_RESULT, `FSC_CMD_WRITE, `FSC_CMD_FETCH,
            `FSC_CMD_SHUTDOWN, 8'h55, 8'hA5, `FSC_CMD_ACTIVE,
            `FSC_CMD_ACTIVE}, 8);
        $display("test states from shutdown done");
        for (k = 0; k < 6; k = k + 1) begin
            @(negedge clk_i);
            meas = (k % 3 == 0) ? 24'h8000_00 : (k % 3 == 1) ? 24'h7FFF_FF
                : $urandom;
            temp = $urandom;
            cmd(k < 3 ? `FSC_CMD_RESULT : `FSC_CMD_TEMP);
            for (b = 0; b < 3; b = b + 1) begin
                fsc_host_model_i.xfer(8'h00, rx);
                got = {got[15:0], rx};
            end
            fsc_host_model_i.close_frame;
            check("result", got, k < 3 ? meas : temp);
        end
        for (k = 0; k < 2; k = k + 1) begin
            a = $urandom;
            d = $urandom;
            b = n_temp;
            cmd(`FSC_CMD_WRITE);
            fsc_host_model_i.xfer(a, rx);
            fsc_host_model_i.xfer(d, rx);
            fsc_host_model_i.close_frame;
            check("write addr", wr_addr, a);
            check("write data", wr_data, d);
            check("temp refresh", n_temp - b, 24'h1);
        end
        $display("test active reads and writes done");
        // here idle is reached via shutdown, not straight from active
        steps({`FSC_CMD_SHUTDOWN, `FSC_CMD_IDLE, 48'h0}, 2);
        // in idle only fetches are sent, no result and no write
        for (k = 0; k < 2; k = k + 1) begin
            a = $urandom;
            coef = $urandom;
            coef_wait = k ? 1000 : 30;
            cmd(`FSC_CMD_FETCH);
            fsc_host_model_i.xfer(a, rx);
            rx = 8'h00;
            // poll for the marker, checking any busy bytes before it; at least one always shows
            for (b = 0; b < 12 && rx !== `FSC_BYTE_READY; b = b + 1) begin
                fsc_host_model_i.xfer(8'h00, rx);
                if (rx !== `FSC_BYTE_READY)
                    check("busy byte", rx, `FSC_BYTE_BUSY);
            end
            check("ready marker", rx, `FSC_BYTE_READY);
            if (rx !== `FSC_BYTE_READY) begin
                wrap_up;
            end
            fsc_host_model_i.xfer(8'h00, rx);
            fsc_host_model_i.close_frame;
            check("coefficient", rx, coef);
            check("coef addr", coef_addr, a);
        end
        $display("test coefficient fetch done");
        steps({`FSC_CMD_ACTIVE, `FSC_CMD_RESET, `FSC_CMD_IDLE,
            `FSC_CMD_RESET, `FSC_CMD_ACTIVE, `FSC_CMD_SHUTDOWN,
            16'h0}, 6);
        $display("test state walk done");
        wrap_up;
    end
endmodule // test_sensor_spi_command_state_machine

// ### design/fsc_cmd_top.v
// command interpreter of the force sensor serial front end
// assumes serial pins are asynchronous and sampled on clk_i; measurement,
// temperature and coefficient sources share clk_i
`timescale 1ns/1ps
`include "fsc_map.vh"
module fsc_cmd_top (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // serial link
    input wire sclk_i,
    input wire select_n_i,
    input wire sdi_i,
    output reg sdo_o,
    output reg sdo_oe_o,
    // conversion data sources
    input wire [23:0] meas_data_i,
    input wire [23:0] temp_data_i,
    // correction coefficient memory
    input wire [7:0] coef_data_i,
    input wire coef_valid_i,
    output reg coef_req_o,
    output reg [7:0] coef_addr_o,
    // register writes
    output reg wr_strobe_o,
    output reg [7:0] wr_addr_o,
    output reg [7:0] wr_data_o,
    output reg temp_refresh_o,
    // device state
    output reg boot_o,
    output reg conv_run_o,
    output reg [1:0] state_o
);

    // ==========================================================
    // frame phases
    localparam PH_IDLE = 3'h0;
    localparam PH_CMD = 3'h1;
    localparam PH_ACK = 3'h2;
    localparam PH_WRITE = 3'h3;
    localparam PH_READ = 3'h4;
    localparam PH_ADDR = 3'h5;
    localparam PH_PREP = 3'h6;
    localparam PH_DROP = 3'h7;

    localparam [31:0] PREP_CYC_W = `FSC_PREP_MAX_CYC;
    localparam [8:0] PREP_CYC = PREP_CYC_W[8:0];

    // ==========================================================
    // pin sampling
    wire [2:0] pins_s;
    wire sclk_s;
    wire sel_n_s;
    wire sdi_s;
    reg sclk_d_reg;
    reg sel_n_d_reg;

    fsc_sync #(
        .WIDTH(3)
    ) u_sync (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .async_i({sclk_i, select_n_i, sdi_i}),
        .rst_val_i(3'b111),
        .sync_o(pins_s)
    );

    assign sclk_s = pins_s[2];
    assign sel_n_s = pins_s[1];
    assign sdi_s = pins_s[0];

    wire sclk_rise = sclk_s & ~sclk_d_reg;
    wire sclk_fall = ~sclk_s & sclk_d_reg;
    // frame opening only counts with the serial clock high; closing counts at any clock level
    wire frame_open = sel_n_d_reg & ~sel_n_s & sclk_s;
    wire frame_close = ~sel_n_d_reg & sel_n_s;

    // ==========================================================
    // byte shifter
    wire byte_done;
    wire [7:0] rx_byte;
    wire shift_sdo;
    reg load_reg;
    reg [7:0] load_byte_reg;

    fsc_shift u_shift (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .clear_i(frame_open),
        .rise_i(sclk_rise & ~sel_n_s),
        .fall_i(sclk_fall & ~sel_n_s),
        .mosi_i(sdi_s),
        .load_i(load_reg),
        .load_byte_i(load_byte_reg),
        .byte_done_o(byte_done),
        .rx_byte_o(rx_byte),
        .sdo_o(shift_sdo)
    );

    // ==========================================================
    // command decision: accept flag and next device state
    reg cmd_ok;
    reg [1:0] state_next;
    reg [2:0] phase_next;
    reg boot_next;

    always @* begin
        cmd_ok = 1'b1;
        state_next = state_o;
        phase_next = PH_ACK;
        boot_next = 1'b0;
        case (rx_byte)
            `FSC_CMD_RESET: begin
                state_next = `FSC_ST_SHUT;
                boot_next = 1'b1;
            end
            `FSC_CMD_SHUTDOWN: begin
                state_next = `FSC_ST_SHUT;
            end
            `FSC_CMD_ACTIVE: begin
                if (state_o == `FSC_ST_ACTIVE) begin
                    cmd_ok = 1'b0;
                end else begin
                    state_next = `FSC_ST_ACTIVE;
                    boot_next = (state_o == `FSC_ST_SHUT);
                end
            end
            `FSC_CMD_IDLE: begin
                // accepted even while active
                state_next = `FSC_ST_IDLE;
                boot_next = (state_o == `FSC_ST_SHUT);
            end
            `FSC_CMD_RESULT, `FSC_CMD_TEMP: begin
                // in idle the answer is acknowledged but stale
                cmd_ok = (state_o != `FSC_ST_SHUT);
                phase_next = PH_READ;
            end
            `FSC_CMD_WRITE: begin
                cmd_ok = (state_o != `FSC_ST_SHUT);
                phase_next = PH_WRITE;
            end
            `FSC_CMD_FETCH: begin
                cmd_ok = (state_o != `FSC_ST_SHUT);
                phase_next = PH_ADDR;
            end
            default: begin
                cmd_ok = 1'b0;
            end
        endcase
        if (!cmd_ok) begin
            state_next = state_o;
            phase_next = PH_DROP;
            boot_next = 1'b0;
        end
    end

    // ==========================================================
    // frame sequencer
    reg [2:0] phase_reg;
    reg [2:0] after_ack_reg;
    reg [23:0] snap_reg;
    reg [1:0] idx_reg;
    reg wr_second_reg;
    reg prep_busy_reg;
    reg prep_done_reg;
    reg marker_sent_reg;
    reg [8:0] prep_cnt_reg;
    reg [7:0] coef_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            phase_reg <= PH_IDLE;
            after_ack_reg <= PH_DROP;
            snap_reg <= 24'h00_0000;
            idx_reg <= 2'h0;
            wr_second_reg <= 1'b0;
            prep_busy_reg <= 1'b0;
            prep_done_reg <= 1'b0;
            marker_sent_reg <= 1'b0;
            prep_cnt_reg <= 9'h000;
            coef_reg <= 8'h00;
            load_reg <= 1'b0;
            load_byte_reg <= 8'hFF;
            sclk_d_reg <= 1'b1;
            sel_n_d_reg <= 1'b1;
            sdo_o <= 1'b1;
            sdo_oe_o <= 1'b0;
            coef_req_o <= 1'b0;
            coef_addr_o <= 8'h00;
            wr_strobe_o <= 1'b0;
            wr_addr_o <= 8'h00;
            wr_data_o <= 8'h00;
            temp_refresh_o <= 1'b0;
            boot_o <= 1'b0;
            conv_run_o <= 1'b0;
            state_o <= `FSC_ST_RESET;
        end else begin
            sclk_d_reg <= sclk_s;
            sel_n_d_reg <= sel_n_s;
            // idle level outside a frame, not the last bit shifted
            sdo_o <= (sel_n_s | frame_open) ? 1'b1 : shift_sdo;
            sdo_oe_o <= ~sel_n_s;
            load_reg <= 1'b0;
            coef_req_o <= 1'b0;
            wr_strobe_o <= 1'b0;
            temp_refresh_o <= 1'b0;
            boot_o <= 1'b0;
            conv_run_o <= (state_o == `FSC_ST_ACTIVE);

            // preparation timer: memory answer or the worst-case bound
            if (prep_busy_reg) begin
                if (coef_valid_i || prep_cnt_reg == 9'h001) begin
                    prep_busy_reg <= 1'b0;
                    prep_done_reg <= 1'b1;
                    coef_reg <= coef_data_i;
                end else begin
                    prep_cnt_reg <= prep_cnt_reg - 9'h001;
                end
            end

            if (frame_open) begin
                phase_reg <= PH_CMD;
            end else if (frame_close) begin
                // a frame cut short drops whatever was pending
                phase_reg <= PH_IDLE;
                prep_busy_reg <= 1'b0;
                prep_done_reg <= 1'b0;
            end else if (byte_done) begin
                load_reg <= 1'b1;
                load_byte_reg <= `FSC_BYTE_FILL;
                case (phase_reg)
                    PH_CMD: begin
                        state_o <= state_next;
                        boot_o <= boot_next;
                        idx_reg <= 2'h0;
                        wr_second_reg <= 1'b0;
                        marker_sent_reg <= 1'b0;
                        snap_reg <= (rx_byte == `FSC_CMD_TEMP) ?
                            temp_data_i : meas_data_i;
                        after_ack_reg <= phase_next;
                        phase_reg <= PH_ACK;
                        load_byte_reg <= cmd_ok ? `FSC_BYTE_ACK :
                            `FSC_BYTE_NACK;
                    end
                    PH_ACK: begin
                        phase_reg <= after_ack_reg;
                        if (after_ack_reg == PH_READ) begin
                            // msb byte first
                            load_byte_reg <= snap_reg[23:16];
                            idx_reg <= 2'h1;
                        end
                    end
                    PH_READ: begin
                        case (idx_reg)
                            2'h1: load_byte_reg <= snap_reg[15:8];
                            2'h2: load_byte_reg <= snap_reg[7:0];
                            default: load_byte_reg <= `FSC_BYTE_FILL;
                        endcase
                        if (idx_reg != 2'h3) begin
                            idx_reg <= idx_reg + 2'h1;
                        end
                    end
                    PH_WRITE: begin
                        // address byte then data byte
                        if (!wr_second_reg) begin
                            wr_addr_o <= rx_byte;
                            wr_second_reg <= 1'b1;
                        end else begin
                            wr_data_o <= rx_byte;
                            wr_strobe_o <= 1'b1;
                            temp_refresh_o <=
                                (state_o == `FSC_ST_ACTIVE);
                            phase_reg <= PH_DROP;
                        end
                    end
                    PH_ADDR: begin
                        coef_addr_o <= rx_byte;
                        coef_req_o <= 1'b1;
                        prep_busy_reg <= 1'b1;
                        prep_done_reg <= 1'b0;
                        prep_cnt_reg <= PREP_CYC;
                        load_byte_reg <= `FSC_BYTE_BUSY;
                        phase_reg <= PH_PREP;
                    end
                    PH_PREP: begin
                        if (marker_sent_reg) begin
                            load_byte_reg <= coef_reg;
                            phase_reg <= PH_DROP;
                        end else if (prep_done_reg) begin
                            load_byte_reg <= `FSC_BYTE_READY;
                            marker_sent_reg <= 1'b1;
                        end else begin
                            load_byte_reg <= `FSC_BYTE_BUSY;
                        end
                    end
                    PH_DROP: begin
                        load_byte_reg <= `FSC_BYTE_FILL;
                    end
                    default: begin
                        phase_reg <= PH_IDLE;
                    end
                endcase
            end
        end
    end

endmodule // fsc_cmd_top

// ### design/fsc_map.vh
// constants for the force sensor serial command front end
// assumes a 10 MHz system clock and a slow mode-3 serial link
//
// How it works
// - reset reboots to shutdown; active or idle from shutdown reload boot
// - shutdown refuses result, write, fetch; active refuses active (nack)
// - mode 3: output moves on falling clock, input taken on rising clock
// - frame opens on a select edge while the serial clock is high, closes on any rising select edge
// - write: command byte, acknowledge byte, then payload bytes in same frame
// - read: after command and acknowledge, response shifts out msb first
// - fetch: address byte, then up to 25 us busy with 0x00 bytes
// - when preparation ends send 0x01 marker then the data byte
// - accepted command answers eight low bits as acknowledge
// - invalid or refused command answers eight high bits
// - results are 24-bit two's complement, three bytes, msb byte first

`ifndef FSC_MAP_VH
`define FSC_MAP_VH

// ==========================================================
// command codes
`define FSC_CMD_RESET 8'h10
`define FSC_CMD_SHUTDOWN 8'h11
`define FSC_CMD_ACTIVE 8'h12
`define FSC_CMD_IDLE 8'h13
`define FSC_CMD_RESULT 8'hC0
`define FSC_CMD_TEMP 8'hC2
`define FSC_CMD_WRITE 8'hE0
`define FSC_CMD_FETCH 8'hD6

// ==========================================================
// device states
`define FSC_ST_SHUT 2'h0
`define FSC_ST_ACTIVE 2'h1
`define FSC_ST_IDLE 2'h2
`define FSC_ST_RESET 2'h0

// ==========================================================
// answer bytes
`define FSC_BYTE_ACK 8'h00
`define FSC_BYTE_NACK 8'hFF
`define FSC_BYTE_BUSY 8'h00
`define FSC_BYTE_READY 8'h01
`define FSC_BYTE_FILL 8'h00

// ==========================================================
// timing
`define FSC_CLK_MHZ 10
`define FSC_PREP_MAX_US 25
`define FSC_PREP_MAX_CYC (`FSC_PREP_MAX_US * `FSC_CLK_MHZ)

`endif

// ### design/fsc_shift.v
// bit-level shifter for the serial link
// assumes rise_i/fall_i are one-cycle pulses of the synchronised clock
`timescale 1ns/1ps
module fsc_shift (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // link events
    input wire clear_i,
    input wire rise_i,
    input wire fall_i,
    input wire mosi_i,
    // next byte to send
    input wire load_i,
    input wire [7:0] load_byte_i,
    // received byte and serial output bit
    output reg byte_done_o,
    output reg [7:0] rx_byte_o,
    output reg sdo_o
);

    reg [7:0] rx_reg;
    reg [7:0] tx_reg;
    reg [2:0] bit_cnt_reg;

    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_reg <= 8'h00;
            tx_reg <= 8'hFF;
            bit_cnt_reg <= 3'h0;
            byte_done_o <= 1'b0;
            rx_byte_o <= 8'h00;
            sdo_o <= 1'b1;
        end else begin
            byte_done_o <= 1'b0;
            if (clear_i) begin
                bit_cnt_reg <= 3'h0;
                tx_reg <= 8'hFF;
                sdo_o <= 1'b1;
            end else begin
                if (rise_i) begin
                    rx_reg <= {rx_reg[6:0], mosi_i};
                    bit_cnt_reg <= bit_cnt_reg + 3'h1;
                    if (bit_cnt_reg == 3'h7) begin
                        byte_done_o <= 1'b1;
                        rx_byte_o <= {rx_reg[6:0], mosi_i};
                    end
                end
                // msb leaves first, one bit per falling edge
                if (fall_i) begin
                    sdo_o <= tx_reg[7];
                    tx_reg <= {tx_reg[6:0], 1'b1};
                end
                if (load_i) begin
                    tx_reg <= load_byte_i;
                end
            end
        end
    end

endmodule // fsc_shift

// ### design/fsc_sync.v
// two-stage synchroniser for a group of pin inputs
// assumes inputs are asynchronous to clk_i
`timescale 1ns/1ps
module fsc_sync #(
    parameter WIDTH = 3
) (
    // clock and reset
    input wire clk_i,
    input wire rst_i,
    // pins, reset value and synchronised copy
    input wire [WIDTH-1:0] async_i,
    input wire [WIDTH-1:0] rst_val_i,
    output reg [WIDTH-1:0] sync_o
);

    reg [WIDTH-1:0] meta_reg;

    // first stage is read only by the second stage
    always @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= rst_val_i;
            sync_o <= rst_val_i;
        end else begin
            meta_reg <= async_i;
            sync_o <= meta_reg;
        end
    end

endmodule // fsc_sync
